// >>> src/glim_defines.svh
`ifndef GLIM_DEFINES_SVH
`define GLIM_DEFINES_SVH

// Pin count and configuration codes
`define GLIM_NPINS       3
`define GLIM_CFG_INPUT   2'h0
`define GLIM_CFG_PUSH    2'h1
`define GLIM_CFG_OPEN    2'h2
// Lamp pin positions
`define GLIM_SPEED_POS   0
`define GLIM_LINK_POS    1
`define GLIM_DUPLEX_POS  2
// Timing
`define GLIM_CLK_HZ      100000000
`define GLIM_BLINK_MS    80
`define GLIM_BLINK_CYC   ((`GLIM_CLK_HZ / 1000) * `GLIM_BLINK_MS)

`endif

// >>> src/glim_pkg.sv
package glim_pkg;
  typedef enum logic [1:0] {
    BLINK_SOLID,
    BLINK_OFF,
    BLINK_HOLD
  } glim_blink_t;
endpackage

// >>> src/glim_gpio_lamp.sv
// Overview of operation
// RULE_01: Each pin is software set as push-pull output, open-drain output or input.
// RULE_02: Each pin switches between general I/O role and lamp role.
// RULE_03: Lamp pins are open-drain: pulled low for lit, released otherwise.
// RULE_04: Speed lamp low at 100M, auto-negotiation, no cable; high at 10M. Code also holds it low at 10M without valid link.
// RULE_05: Link lamp held low with valid link and no blink running.
// RULE_06: Activity with valid link turns link lamp off for 80 ms.
// RULE_07: After off pulse lamp stays on 80 ms minimum; repeats on activity.
// RULE_08: Duplex lamp driven low in full duplex, released otherwise. Code releases it in full duplex without valid link.
// RULE_09: Blink intervals counted on core clock with derived terminal count.
`timescale 1ns/1ps
`include "glim_defines.svh"

module glim_gpio_lamp #(
  parameter int unsigned BLINK_CYC = `GLIM_BLINK_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Pin configuration
  input  wire logic [5:0] pin_cfg,
  input  wire logic [2:0] lamp_en,
  input  wire logic [2:0] gpio_out,
  output logic      [2:0] gpio_in,
  // Status from MAC/PHY
  input  wire logic       speed_10,
  input  wire logic       link_valid,
  input  wire logic       autoneg_busy,
  input  wire logic       cable_off,
  input  wire logic       full_duplex,
  input  wire logic       tx_active,
  input  wire logic       rx_active,
  // Pins
  input  wire logic [2:0] pin_i,
  output logic      [2:0] pin_o,
  output logic      [2:0] pin_oe
);

  logic [2:0]              pin_s1_q;
  logic [2:0]              pin_s2_q;
  glim_pkg::glim_blink_t   blink_q;
  logic [31:0]             blink_cnt_q;
  logic                    act;
  logic [2:0]              lamp_n;
  logic                    speed_lamp_n;
  logic                    link_activity_lamp_n;
  logic                    duplex_lamp_n;
  logic                    blink_solid;
  logic                    blink_off;
  logic                    blink_hold;

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (reset);

  function automatic logic [1:0] cfg_of(input logic [5:0] c,
                                        input int unsigned i);
    cfg_of = c[2*i +: 2];
  endfunction

  // Pin input synchroniser
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      gpio_in  <= 3'h0;
    end
    else
    begin
      pin_s1_q <= pin_i;
      pin_s2_q <= pin_s1_q;
      gpio_in  <= pin_s2_q;
    end
  end

  assign act = (tx_active | rx_active) & link_valid;

  // Activity blink timer
  always_ff @(posedge core_clk)
  begin
    if (reset || !link_valid)
    begin
      blink_q     <= glim_pkg::BLINK_SOLID;
      blink_cnt_q <= 32'h0;
    end
    else
    begin
      case (blink_q)
        glim_pkg::BLINK_SOLID:
          if (act)
          begin
            blink_q     <= glim_pkg::BLINK_OFF; // see RULE_06
            blink_cnt_q <= 32'h0;
          end
        glim_pkg::BLINK_OFF:
          if (blink_cnt_q == BLINK_CYC - 1) // see RULE_09
          begin
            blink_q     <= glim_pkg::BLINK_HOLD; // see RULE_07
            blink_cnt_q <= 32'h0;
          end
          else
            blink_cnt_q <= blink_cnt_q + 32'h1;
        glim_pkg::BLINK_HOLD:
          if (blink_cnt_q == BLINK_CYC - 1)
          begin
            blink_q     <= glim_pkg::BLINK_SOLID; // see RULE_07
            blink_cnt_q <= 32'h0;
          end
          else
            blink_cnt_q <= blink_cnt_q + 32'h1;
        default:
          blink_q <= glim_pkg::BLINK_SOLID;
      endcase
    end
  end

  // Lamp levels
  assign speed_lamp_n = speed_10 & link_valid & ~autoneg_busy
                        & ~cable_off; // see RULE_04
  assign blink_solid = (blink_q == glim_pkg::BLINK_SOLID);
  assign blink_off   = (blink_q == glim_pkg::BLINK_OFF);
  assign blink_hold  = (blink_q == glim_pkg::BLINK_HOLD);
  assign link_activity_lamp_n = ~link_valid | blink_off; // see RULE_05
  assign duplex_lamp_n = ~(full_duplex & link_valid); // see RULE_08
  assign lamp_n = {duplex_lamp_n, link_activity_lamp_n, speed_lamp_n};

  // Pin drivers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_o  <= 3'h0;
      pin_oe <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < `GLIM_NPINS; i++)
      begin
        if (lamp_en[i])
        begin
          pin_o[i]  <= 1'b0;
          pin_oe[i] <= ~lamp_n[i]; // see RULE_02 RULE_03
        end
        else
        begin
          case (cfg_of(pin_cfg, i)) // see RULE_01
            `GLIM_CFG_PUSH:
            begin
              pin_o[i]  <= gpio_out[i];
              pin_oe[i] <= 1'b1;
            end
            `GLIM_CFG_OPEN:
            begin
              pin_o[i]  <= 1'b0;
              pin_oe[i] <= ~gpio_out[i];
            end
            default:
            begin
              pin_o[i]  <= 1'b0;
              pin_oe[i] <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  sequence off_pulse_s;
    blink_off [*8];
  endsequence

  sequence hold_entry_s;
    $rose(blink_hold) && link_valid;
  endsequence

  // Activity blink
  chk_blink_start: assert property ( // see RULE_06
    blink_solid && act |=> blink_off)
    else $error("blink did not start");
  chk_off_seen: assert property ( // see RULE_06
    $rose(blink_off) && BLINK_CYC > 14 ##0 link_valid [*8] |-> off_pulse_s)
    else $error("off pulse broken");
  chk_off_len: assert property ( // see RULE_09
    blink_off && blink_cnt_q < BLINK_CYC - 1 && link_valid
      |=> blink_off || !link_valid)
    else $error("off pulse too short");
  chk_off_end: assert property ( // see RULE_07
    blink_off && blink_cnt_q == BLINK_CYC - 1 && link_valid
      |=> blink_hold)
    else $error("on interval not entered");
  chk_blink_hold: assert property ( // see RULE_07
    hold_entry_s |=> blink_hold || !link_valid)
    else $error("on interval cut short");
  chk_hold_len: assert property ( // see RULE_07
    blink_hold && blink_cnt_q < BLINK_CYC - 1 && link_valid
      |=> blink_hold || !link_valid)
    else $error("on interval too short");
  chk_cnt_bound: assert property ( // see RULE_09
    !blink_solid |-> blink_cnt_q < BLINK_CYC)
    else $error("blink counter overrun");
  chk_link_abort: assert property ( // see RULE_05
    !link_valid |=> blink_solid)
    else $error("blink kept without link");

  // Lamp pins
  chk_lamp_drive: assert property ( // see RULE_03
    lamp_en[1] |=> pin_o[1] == 1'b0)
    else $error("lamp pin driven high");
  chk_link_off: assert property ( // see RULE_06
    lamp_en[1] && blink_off |=> !pin_oe[1] || $changed(lamp_en[1]))
    else $error("link lamp not dark");
  chk_link_solid: assert property ( // see RULE_05
    lamp_en[1] && link_valid && !blink_off
      |=> pin_oe[1] || $changed(lamp_en[1]))
    else $error("link lamp not lit");
  chk_speed_lamp: assert property ( // see RULE_04
    lamp_en[0] && (autoneg_busy || cable_off || !speed_10) && $stable(lamp_en)
      |=> pin_oe[0])
    else $error("speed lamp not lit");
  chk_role_switch: assert property ( // see RULE_02
    lamp_en[0] |=> !pin_o[0] && pin_oe[0] == !$past(speed_lamp_n))
    else $error("lamp role not taken");
  chk_duplex_lamp: assert property ( // see RULE_08
    lamp_en[2] && $stable(lamp_en) |=> pin_oe[2] == $past(duplex_lamp_n == 0))
    else $error("duplex lamp wrong");

  // General pins
  chk_push_pull: assert property ( // see RULE_01
    !lamp_en[0] && pin_cfg[1:0] == `GLIM_CFG_PUSH
      |=> pin_oe[0] && pin_o[0] == $past(gpio_out[0]))
    else $error("push-pull pin wrong");
  chk_open_drain: assert property ( // see RULE_01
    !lamp_en[1] && pin_cfg[3:2] == `GLIM_CFG_OPEN
      |=> !pin_o[1] && pin_oe[1] == !$past(gpio_out[1]))
    else $error("open-drain pin wrong");
  chk_input_float: assert property ( // see RULE_01
    !lamp_en[2]
      && (pin_cfg[5:4] == `GLIM_CFG_INPUT || pin_cfg[5:4] == 2'h3)
      |=> !pin_oe[2])
    else $error("input pin driven");

endmodule // glim_gpio_lamp

// >>> testbench/glim_lamp_board.sv
`timescale 1ns/1ps
module glim_lamp_board (
  // Driven by the block
  input  wire logic [2:0] pin_o,
  input  wire logic [2:0] pin_oe,
  // Seen by the block
  output logic      [2:0] pin_i
);
  // Lamp to supply acts as pull-up
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      pin_i[i] = pin_oe[i] ? pin_o[i] : 1'b1;
  end
endmodule // glim_lamp_board

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  localparam int BC = 20;
  logic       core_clk = 0, reset = 1;
  logic [5:0] pin_cfg = 0;
  logic [2:0] lamp_en = 0, gpio_out = 0, gpio_in, pin_i, pin_o, pin_oe;
  logic [4:0] st = 0;
  logic       act = 0, rx = 0;
  int         fail_count = 0, total_checks = 0, n;
  logic [25:0] rows [8] = '{
    {6'h15, 3'h0, 3'h5, 5'h00, 3'h5, 3'h7, 3'h5},
    {6'h2A, 3'h0, 3'h5, 5'h00, 3'h0, 3'h2, 3'h5},
    {6'h3C, 3'h0, 3'h5, 5'h00, 3'h0, 3'h0, 3'h7},
    {6'h00, 3'h7, 3'h0, 5'h19, 3'h0, 3'h6, 3'h1},
    {6'h00, 3'h7, 3'h0, 5'h08, 3'h0, 3'h3, 3'h4},
    {6'h00, 3'h7, 3'h0, 5'h1C, 3'h0, 3'h3, 3'h4},
    {6'h00, 3'h7, 3'h0, 5'h1A, 3'h0, 3'h3, 3'h4},
    {6'h00, 3'h7, 3'h0, 5'h11, 3'h0, 3'h1, 3'h6}};
  glim_gpio_lamp #(.BLINK_CYC(BC)) dut (.core_clk(core_clk), .reset(reset),
    .pin_cfg(pin_cfg), .lamp_en(lamp_en), .gpio_out(gpio_out),
    .gpio_in(gpio_in), .speed_10(st[4]), .link_valid(st[3]),
    .autoneg_busy(st[2]), .cable_off(st[1]), .full_duplex(st[0]),
    .tx_active(act), .rx_active(rx), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe(pin_oe));
  glim_lamp_board board (.pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));
  initial
  begin
    forever #5 core_clk = ~core_clk;
  end
  task wrap_up;
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Count cycles with link lamp drive at level v
  task run(input logic v);
    n = 0;
    while (pin_oe[1] === v && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 100)
    begin
      fail_count++;
      wrap_up;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    `CHK("reset oe", 3'h0, pin_oe)
    `CHK("reset in", 3'h0, gpio_in)
    @(posedge core_clk) reset <= 0;
    foreach (rows[r])
    begin
      @(posedge core_clk);
      {pin_cfg, lamp_en, gpio_out, st} <= rows[r][25:9];
      repeat (5) @(posedge core_clk);
      #1;
      `CHK("pin_o", rows[r][8:6], pin_o)
      `CHK("pin_oe", rows[r][5:3], pin_oe)
      `CHK("gpio_in", rows[r][2:0], gpio_in)
    end
    // Valid link at 100M half duplex, lamp settles lit
    @(posedge core_clk) st <= 5'h08;
    repeat (3) @(posedge core_clk);
    act <= 1;
    #1;
    run(1);
    run(0);
    `CHK("off len", BC, n)
    run(1);
    `CHK("on len", BC + 1, n)
    run(0);
    `CHK("again", BC, n)
    // Receive activity alone keeps the blink going
    @(posedge core_clk)
    begin
      act <= 0;
      rx  <= 1;
    end
    #1;
    run(1);
    run(0);
    `CHK("rx off", BC, n)
    wrap_up;
  end
endmodule // testbench
